// >>> inc/dcsp_pkg.sv
// dcsp_pkg: constants, state types and field layout of the dual channel serial port
// assumes one 50 MHz clock, a synchronous reset and the plain register port
package dcsp_pkg;
	localparam int unsigned CH_N       = 2;
	localparam int unsigned AW         = 9;
	localparam int unsigned CH_SEL_BIT = 8;

	localparam logic [7:0] OFS_DATA = 8'h00;
	localparam logic [7:0] OFS_CTRL = 8'h04;
	localparam logic [7:0] OFS_STAT = 8'h08;
	localparam logic [7:0] OFS_DIV  = 8'h0C;
	localparam logic [7:0] OFS_EN   = 8'h10;
	localparam logic [7:0] OFS_DLY  = 8'h14;
	localparam logic [7:0] OFS_MASK = 8'h18;

	localparam logic [18:0] CTRL_RST = 19'h0_1020;
	localparam logic [15:0] DIV_RST  = 16'h00FF;
	localparam logic [23:0] DLY_RST  = 24'h01_0101;
	localparam logic [5:0]  STAT_RST = 6'h06;
	localparam logic [16:0] RXD_RST  = 17'h0_0000;

	localparam int unsigned CB_SZ    = 0;
	localparam int unsigned CB_CLOCK_POLARITY  = 2;
	localparam int unsigned CB_CLOCK_PHASE  = 3;
	localparam int unsigned CB_MSB_FIRST  = 4;
	localparam int unsigned CB_MS    = 5;
	localparam int unsigned CB_SELECT_POLARITY = 8;
	localparam int unsigned CB_SSMSK = 10;
	localparam int unsigned CB_LOOP  = 11;
	localparam int unsigned CB_SELECT_OUTPUT_LEVEL = 12;
	localparam int unsigned CB_SELECT_DRIVE_MODE = 13;
	localparam int unsigned CB_RXFL  = 19;
	localparam int unsigned CB_TXFL  = 20;

	localparam int unsigned SB_RXRDY = 0;
	localparam int unsigned SB_OVR   = 3;
	localparam int unsigned SB_SSCHG = 4;
	localparam int unsigned SB_TXDN  = 5;

	localparam int unsigned DL_START = 0;
	localparam int unsigned DL_BURST = 8;
	localparam int unsigned DL_STOP  = 16;

	typedef enum logic [2:0] {ST_IDLE, ST_START, ST_SHIFT, ST_BURST, ST_STOP} dcsp_st_t;

	typedef struct packed {
		logic [18:0] ctrl;
		logic [15:0] div;
		logic        en;
		logic [23:0] dly;
		logic [5:0]  mask;
		logic        rxrdy;
		logic        ovr;
		logic        sschg;
		logic        txdone;
		logic [16:0] txh;
		logic        txv;
		logic [16:0] rxd;
		logic [16:0] tsh;
		logic [16:0] rsh;
		dcsp_st_t    st;
		logic [5:0]  ecnt;
		logic [7:0]  dcnt;
		logic        sck;
		logic        ss;
		logic        mosi;
		logic        miso;
		logic        mst_oe;
		logic        miso_oe;
		logic        sck_in;
		logic        sel_q;
		logic        dtx;
		logic        drx;
	} dcsp_ch_t;

	typedef struct packed {
		dcsp_ch_t [CH_N-1:0] ch;
		logic [31:0]         rdata;
		logic                irq;
	} dcsp_top_st_t;
endpackage : dcsp_pkg

// >>> rtl/dcsp_tick.sv
// dcsp_tick: half-period tick of one channel's serial clock and delays
// assumes div_i is held stable while run_i is high
`timescale 1ns/1ps
`default_nettype none
module dcsp_tick (
	input  wire logic        mclk_i,
	input  wire logic        sys_rst_i,
	input  wire logic        run_i,
	input  wire logic [15:0] div_i,
	output logic             tick_o
);
	import dcsp_pkg::*;

	typedef struct packed {
		logic [15:0] cnt;
		logic        tick;
	} dcsp_tick_t;

	dcsp_tick_t q;
	dcsp_tick_t d;

	// greater-or-equal so that a smaller divisor written mid-count cannot overrun
	always_comb begin
		d = q;
		d.tick = 1'b0;
		if (!run_i) begin
			d.cnt = 16'h0000;
		end else if (q.cnt >= div_i) begin
			d.cnt = 16'h0000;
			d.tick = 1'b1;
		end else begin
			d.cnt = q.cnt + 16'h0001;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign tick_o = q.tick;
endmodule : dcsp_tick
`default_nettype wire

// >>> rtl/dcsp_top.sv
// dcsp_top: two channel synchronous serial port with its register file
// assumes pins already synchronous to mclk_i and a bus master that never waits
`timescale 1ns/1ps
`default_nettype none
module dcsp_top (
	input  wire logic                           mclk_i,
	input  wire logic                           sys_rst_i,
	input  wire logic [dcsp_pkg::AW-1:0]        addr_i,
	input  wire logic [31:0]                    wdata_i,
	input  wire logic                           wr_i,
	input  wire logic                           rd_i,
	output logic      [31:0]                    rdata_o,
	output logic                                irq_o,
	input  wire logic [dcsp_pkg::CH_N-1:0]      ss_i,
	input  wire logic [dcsp_pkg::CH_N-1:0]      sck_i,
	input  wire logic [dcsp_pkg::CH_N-1:0]      mosi_i,
	input  wire logic [dcsp_pkg::CH_N-1:0]      miso_i,
	output logic      [dcsp_pkg::CH_N-1:0]      ss_o,
	output logic      [dcsp_pkg::CH_N-1:0]      ss_oe_o,
	output logic      [dcsp_pkg::CH_N-1:0]      sck_o,
	output logic      [dcsp_pkg::CH_N-1:0]      sck_oe_o,
	output logic      [dcsp_pkg::CH_N-1:0]      mosi_o,
	output logic      [dcsp_pkg::CH_N-1:0]      mosi_oe_o,
	output logic      [dcsp_pkg::CH_N-1:0]      miso_o,
	output logic      [dcsp_pkg::CH_N-1:0]      miso_oe_o,
	output logic      [dcsp_pkg::CH_N-1:0]      dma_tx_req_o,
	output logic      [dcsp_pkg::CH_N-1:0]      dma_rx_req_o
);
	import dcsp_pkg::*;

	function automatic logic [4:0] flen(input logic [1:0] sz);
		case (sz)
			2'h0:    flen = 5'd8;
			2'h1:    flen = 5'd9;
			2'h2:    flen = 5'd16;
			default: flen = 5'd17;
		endcase
	endfunction : flen

	function automatic logic [5:0] stv(input dcsp_ch_t x);
		stv = {x.txdone, x.sschg, x.ovr, x.st == ST_IDLE, ~x.txv, x.rxrdy};
	endfunction : stv

	function automatic dcsp_top_st_t rstv();
		dcsp_top_st_t r;
		r = '0;
		for (int c = 0; c < CH_N; c++) begin
			r.ch[c].ctrl = CTRL_RST;
			r.ch[c].div = DIV_RST;
			r.ch[c].dly = DLY_RST;
			r.ch[c].rxd = RXD_RST;
			r.ch[c].sck = CTRL_RST[CB_CLOCK_POLARITY];
			r.ch[c].ss = ~CTRL_RST[CB_SELECT_POLARITY];
		end
		rstv = r;
	endfunction : rstv

	localparam dcsp_top_st_t RST_ST = rstv();

	dcsp_top_st_t       q;
	dcsp_top_st_t       d;
	logic [CH_N-1:0]    fin;
	logic [CH_N-1:0]    sel;
	logic [CH_N-1:0]    tick;

	logic        hit;
	logic [7:0]  ofs;
	logic [4:0]  n;
	logic [16:0] msk;
	logic [16:0] rl;
	logic        ms;
	logic        msb_first;
	logic        lead;
	logic        samp;
	logic        ev;
	logic        b;

	always_comb begin
		d = q;
		hit = 1'b0;
		ofs = addr_i[7:0];
		n = 5'd8;
		msk = 17'h0_0000;
		rl = 17'h0_0000;
		ms = 1'b0;
		msb_first = 1'b0;
		lead = 1'b0;
		samp = 1'b0;
		ev = 1'b0;
		b = 1'b0;
		fin = '0;
		sel = '0;
		d.rdata = 32'h0000_0000;
		d.irq = 1'b0;
		for (int c = 0; c < CH_N; c++) begin
			hit = (addr_i[CH_SEL_BIT] == c[0]);
			n = flen(q.ch[c].ctrl[CB_SZ+:2]);
			msk = 17'h1_FFFF >> (5'd17 - n);
			ms = q.ch[c].ctrl[CB_MS];
			msb_first = q.ch[c].ctrl[CB_MSB_FIRST];
			ev = 1'b0;
			lead = 1'b0;

			// flag clears go first so that an engine event in the same cycle wins
			if (wr_i && hit && ofs == OFS_STAT) begin
				if (wdata_i[SB_RXRDY]) d.ch[c].rxrdy = 1'b0;
				if (wdata_i[SB_OVR]) d.ch[c].ovr = 1'b0;
				if (wdata_i[SB_SSCHG]) d.ch[c].sschg = 1'b0;
				if (wdata_i[SB_TXDN]) d.ch[c].txdone = 1'b0;
			end
			if (rd_i && hit) begin
				case (ofs)
					OFS_DATA: begin
						d.rdata = {15'h0000, q.ch[c].rxd};
						d.ch[c].rxrdy = 1'b0;
					end
					OFS_CTRL: d.rdata = {13'h0000, q.ch[c].ctrl};
					OFS_STAT: d.rdata = {26'h000_0000, stv(q.ch[c])};
					OFS_DIV:  d.rdata = {16'h0000, q.ch[c].div};
					OFS_EN:   d.rdata = {31'h0000_0000, q.ch[c].en};
					OFS_DLY:  d.rdata = {8'h00, q.ch[c].dly};
					OFS_MASK: d.rdata = {26'h000_0000, q.ch[c].mask};
					default:  d.rdata = 32'h0000_0000;
				endcase
			end

			// loop-back takes the bit on its way out, so the pins cannot disturb reception
			if (q.ch[c].ctrl[CB_LOOP]) begin
				b = msb_first ? q.ch[c].tsh[n-1] : q.ch[c].tsh[0];
			end else begin
				b = ms ? miso_i[c] : mosi_i[c];
			end
			sel[c] = q.ch[c].ctrl[CB_SSMSK] | (ss_i[c] == q.ch[c].ctrl[CB_SELECT_POLARITY]);
			d.ch[c].sck_in = sck_i[c];
			d.ch[c].sel_q = sel[c];

			if (!q.ch[c].en) begin
				d.ch[c].st = ST_IDLE;
				d.ch[c].ecnt = 6'h00;
			end else if (ms) begin
				case (q.ch[c].st)
					ST_IDLE: begin
						if (q.ch[c].txv) begin
							d.ch[c].tsh = q.ch[c].txh;
							d.ch[c].txv = 1'b0;
							d.ch[c].ecnt = 6'h00;
							d.ch[c].st = ST_START;
							d.ch[c].dcnt = q.ch[c].dly[DL_START+:8];
						end
					end
					ST_START, ST_BURST: begin
						if (tick[c]) begin
							if (q.ch[c].dcnt == 8'h00) begin
								d.ch[c].st = ST_SHIFT;
							end else begin
								d.ch[c].dcnt = q.ch[c].dcnt - 8'h01;
							end
						end
					end
					ST_SHIFT: begin
						if (tick[c]) begin
							ev = 1'b1;
							lead = ~q.ch[c].ecnt[0];
							d.ch[c].sck = ~q.ch[c].sck;
						end
					end
					ST_STOP: begin
						if (tick[c]) begin
							if (q.ch[c].dcnt == 8'h00) begin
								d.ch[c].st = ST_IDLE;
							end else begin
								d.ch[c].dcnt = q.ch[c].dcnt - 8'h01;
							end
						end
					end
					default: d.ch[c].st = ST_IDLE;
				endcase
			end else begin
				if (sel[c] != q.ch[c].sel_q) d.ch[c].sschg = 1'b1;
				if (!sel[c]) begin
					d.ch[c].st = ST_IDLE;
					d.ch[c].ecnt = 6'h00;
				end else if (q.ch[c].st != ST_SHIFT) begin
					// an empty holding register shifts out zeros rather than stale data
					d.ch[c].tsh = q.ch[c].txv ? q.ch[c].txh : 17'h0_0000;
					d.ch[c].txv = 1'b0;
					d.ch[c].ecnt = 6'h00;
					d.ch[c].st = ST_SHIFT;
				end else if (sck_i[c] != q.ch[c].sck_in) begin
					ev = 1'b1;
					lead = (sck_i[c] != q.ch[c].ctrl[CB_CLOCK_POLARITY]);
				end
			end

			samp = lead ^ q.ch[c].ctrl[CB_CLOCK_PHASE];
			if (ev) begin
				rl = q.ch[c].rsh >> 1;
				rl[n-1] = b;
				if (samp) begin
					d.ch[c].rsh = msb_first ? {q.ch[c].rsh[15:0], b} : rl;
				end else if (q.ch[c].ecnt != 6'h00) begin
					d.ch[c].tsh = msb_first ? {q.ch[c].tsh[15:0], 1'b0} : {1'b0, q.ch[c].tsh[16:1]};
				end
				d.ch[c].ecnt = q.ch[c].ecnt + 6'h01;
				fin[c] = (q.ch[c].ecnt == {n, 1'b0} - 6'h01);
			end
			if (fin[c]) begin
				d.ch[c].rxd = d.ch[c].rsh & msk;
				d.ch[c].rxrdy = 1'b1;
				if (q.ch[c].rxrdy) d.ch[c].ovr = 1'b1;
				d.ch[c].ecnt = 6'h00;
				if (!ms) begin
					d.ch[c].st = ST_IDLE;
				end else if (q.ch[c].txv) begin
					d.ch[c].tsh = q.ch[c].txh;
					d.ch[c].txv = 1'b0;
					d.ch[c].rsh = 17'h0_0000;
					d.ch[c].st = ST_BURST;
					d.ch[c].dcnt = q.ch[c].dly[DL_BURST+:8];
				end else begin
					d.ch[c].st = ST_STOP;
					d.ch[c].dcnt = q.ch[c].dly[DL_STOP+:8];
					d.ch[c].txdone = 1'b1;
				end
			end

			// writes after the engine, so a word written while one is loaded is kept
			if (wr_i && hit) begin
				case (ofs)
					OFS_DATA: begin
						d.ch[c].txh = wdata_i[16:0];
						d.ch[c].txv = 1'b1;
					end
					OFS_CTRL: begin
						d.ch[c].ctrl = wdata_i[18:0];
						if (wdata_i[CB_TXFL]) d.ch[c].txv = 1'b0;
						if (wdata_i[CB_RXFL]) begin
							d.ch[c].rxd = RXD_RST;
							d.ch[c].rxrdy = 1'b0;
						end
					end
					OFS_DIV:  d.ch[c].div = wdata_i[15:0];
					OFS_EN:   d.ch[c].en = wdata_i[0];
					OFS_DLY:  d.ch[c].dly = wdata_i[23:0];
					OFS_MASK: d.ch[c].mask = wdata_i[5:0];
					default:  d.ch[c].mask = d.ch[c].mask;
				endcase
			end

			// pin drivers, all taken from the next state so they leave a flip-flop
			if (!d.ch[c].ctrl[CB_MS] || d.ch[c].st != ST_SHIFT) begin
				d.ch[c].sck = d.ch[c].ctrl[CB_CLOCK_POLARITY];
			end
			if (d.ch[c].ctrl[CB_SELECT_DRIVE_MODE]) begin
				d.ch[c].ss = d.ch[c].ctrl[CB_SELECT_OUTPUT_LEVEL];
			end else begin
				d.ch[c].ss = (d.ch[c].st != ST_IDLE) ~^ d.ch[c].ctrl[CB_SELECT_POLARITY];
			end
			d.ch[c].mosi = msb_first ? d.ch[c].tsh[n-1] : d.ch[c].tsh[0];
			d.ch[c].miso = d.ch[c].mosi;
			d.ch[c].mst_oe = d.ch[c].en & d.ch[c].ctrl[CB_MS];
			d.ch[c].miso_oe = d.ch[c].en & ~d.ch[c].ctrl[CB_MS] & sel[c];
			d.ch[c].dtx = d.ch[c].en & ~d.ch[c].txv;
			d.ch[c].drx = d.ch[c].rxrdy;
			d.irq = d.irq | (|(stv(d.ch[c]) & d.ch[c].mask));
		end
	end

	always_ff @(posedge mclk_i) begin
		if (sys_rst_i) begin
			q <= RST_ST;
		end else begin
			q <= d;
		end
	end

	genvar g;
	generate
		for (g = 0; g < CH_N; g++) begin : g_ch
			dcsp_tick u_tick (
				.mclk_i    (mclk_i),
				.sys_rst_i (sys_rst_i),
				.run_i     (q.ch[g].en && q.ch[g].ctrl[CB_MS] && q.ch[g].st != ST_IDLE),
				.div_i     (q.ch[g].div),
				.tick_o    (tick[g])
			);
			assign ss_o[g] = q.ch[g].ss;
			assign ss_oe_o[g] = q.ch[g].mst_oe;
			assign sck_o[g] = q.ch[g].sck;
			assign sck_oe_o[g] = q.ch[g].mst_oe;
			assign mosi_o[g] = q.ch[g].mosi;
			assign mosi_oe_o[g] = q.ch[g].mst_oe;
			assign miso_o[g] = q.ch[g].miso;
			assign miso_oe_o[g] = q.ch[g].miso_oe;
			assign dma_tx_req_o[g] = q.ch[g].dtx;
			assign dma_rx_req_o[g] = q.ch[g].drx;
		end
	endgenerate

	assign rdata_o = q.rdata;
	assign irq_o = q.irq;

	chk_enable_readback: assert property (
		@(posedge mclk_i) disable iff (sys_rst_i)
		rd_i && !addr_i[CH_SEL_BIT] && addr_i[7:0] == OFS_EN
		|=> rdata_o == {31'h0000_0000, $past(q.ch[0].en)}
	) else $error("enable read back wrong");

	chk_reset_ctrl: assert property (
		@(posedge mclk_i) disable iff (sys_rst_i)
		$fell(sys_rst_i) |-> q.ch[1].ctrl == CTRL_RST && q.ch[1].div == DIV_RST
	) else $error("control or divider reset value wrong");

	chk_reset_status: assert property (
		@(posedge mclk_i) disable iff (sys_rst_i)
		$fell(sys_rst_i) |-> stv(q.ch[0]) == STAT_RST && q.ch[0].dly == DLY_RST
			&& q.ch[0].rxd == RXD_RST && !q.ch[0].en
	) else $error("status, delay or data reset value wrong");

	chk_tx_flush: assert property (
		@(posedge mclk_i) disable iff (sys_rst_i)
		wr_i && !addr_i[CH_SEL_BIT] && addr_i[7:0] == OFS_CTRL && wdata_i[CB_TXFL]
		|=> !q.ch[0].txv
	) else $error("transmit holding not flushed");

	chk_pin_roles: assert property (
		@(posedge mclk_i) disable iff (sys_rst_i)
		(q.ch[0].en && q.ch[0].ctrl[CB_MS]) == (sck_oe_o[0] && mosi_oe_o[0] && ss_oe_o[0])
	) else $error("master pins not driven by mode");

	chk_miso_slave: assert property (
		@(posedge mclk_i) disable iff (sys_rst_i)
		miso_oe_o[0] |-> !mosi_oe_o[0] && !sck_oe_o[0] && !q.ch[0].ctrl[CB_MS]
	) else $error("master-in driven outside slave mode");

	chk_frame_done: assert property (
		@(posedge mclk_i) disable iff (sys_rst_i)
		fin[0] && !wr_i |=> q.ch[0].rxrdy && dma_rx_req_o[0]
	) else $error("received frame not flagged");

	chk_sck_quiet: assert property (
		@(posedge mclk_i) disable iff (sys_rst_i)
		$changed(sck_o[0]) && $stable(q.ch[0].ctrl) && $past(q.ch[0].ctrl[CB_MS])
		|-> $past(q.ch[0].st) == ST_SHIFT || !q.ch[0].en
	) else $error("serial clock moved outside a frame");

	chk_select_active: assert property (
		@(posedge mclk_i) disable iff (sys_rst_i)
		q.ch[0].ctrl[CB_MS] && !q.ch[0].ctrl[CB_SELECT_DRIVE_MODE] && q.ch[0].st != ST_IDLE
		|-> ss_o[0] == q.ch[0].ctrl[CB_SELECT_POLARITY]
	) else $error("select not active during frame");

	chk_start_delay: assert property (
		@(posedge mclk_i) disable iff (sys_rst_i)
		$rose(q.ch[0].st == ST_START) && $stable(q.ch[0].dly)
		|-> q.ch[0].dcnt == q.ch[0].dly[DL_START+:8]
	) else $error("start delay not loaded");
endmodule : dcsp_top
`default_nettype wire

// >>> test/dcsp_peer.sv
// dcsp_peer: far side serial slave, mode 0, eight bits, msb first
// assumes the pins it watches are synchronous to mclk_i
`timescale 1ns/1ps
`default_nettype none
module dcsp_peer (
	input  wire logic       mclk_i,
	input  wire logic       sys_rst_i,
	input  wire logic       ss_i,
	input  wire logic       sck_i,
	input  wire logic       mosi_i,
	input  wire logic [7:0] word_i,
	output logic            miso_o,
	output logic [7:0]      got_o
);
	logic       sck_q;
	logic       ss_q;
	logic [7:0] sh_q;
	always_ff @(posedge mclk_i) begin
		sck_q <= sck_i;
		ss_q  <= ss_i;
		if (sys_rst_i) begin
			miso_o <= 1'b0;
			got_o  <= '0;
			sh_q   <= '0;
		end else if (ss_i) begin
			// released line toggles so a stale bit never passes
			miso_o <= ~miso_o;
		end else if (ss_q) begin
			sh_q   <= word_i;
			miso_o <= word_i[7];
		end else if (sck_i && !sck_q) begin
			got_o <= {got_o[6:0], mosi_i};
		end else if (!sck_i && sck_q) begin
			sh_q   <= {sh_q[6:0], 1'b0};
			miso_o <= sh_q[6];
		end
	end
endmodule : dcsp_peer
`default_nettype wire

// >>> test/test_dcsp_top.sv
// test_dcsp_top: register, master and loop-back checks of the serial port
// assumes the peer model on channel 0 and one 50 MHz clock
`timescale 1ns/1ps
`default_nettype none
module test_dcsp_top;
	import dcsp_pkg::*;
	typedef struct {logic [31:0] exp; string name;} dcsp_note_t;
	logic              mclk_i = 1'b0;
	logic              sys_rst_i = 1'b1;
	logic [AW-1:0]     addr_i = '0;
	logic [31:0]       wdata_i = '0;
	logic              wr_i = 1'b0;
	logic              rd_i = 1'b0;
	logic [CH_N-1:0]   ss_i = '1;
	logic [CH_N-1:0]   sck_i = '0;
	logic [CH_N-1:0]   mosi_i = '0;
	logic              miso_b = 1'b0;
	logic [7:0]        peer_word = '0;
	wire logic [7:0]   peer_got;
	wire logic         peer_miso;
	wire logic [31:0]  rdata_o;
	wire logic         irq_o;
	wire logic [CH_N-1:0] ss_o, ss_oe_o, sck_o, sck_oe_o, mosi_o, mosi_oe_o, miso_o, miso_oe_o;
	wire logic [CH_N-1:0] dma_tx_req_o, dma_rx_req_o;
	logic              slv_on = 1'b0;
	logic              slv_sck = 1'b0;
	logic              slv_mosi = 1'b0;
	logic [7:0]        slv_got;
	logic [7:0]        slv_word;
	int                miscompares = 0;
	int                cmp_count = 0;
	int                cycles = 0;
	dcsp_note_t        notes[$];
	dcsp_note_t        n;
	logic              rd_seen = 1'b0;
	logic [31:0]       tx;
	int                sz;
	int                base;

	always #10 mclk_i = ~mclk_i;

	dcsp_top uut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
		.wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o), .ss_i(ss_i),
		.sck_i(sck_i), .mosi_i(mosi_i), .miso_i({miso_b, peer_miso}), .ss_o(ss_o),
		.ss_oe_o(ss_oe_o), .sck_o(sck_o), .sck_oe_o(sck_oe_o), .mosi_o(mosi_o),
		.mosi_oe_o(mosi_oe_o), .miso_o(miso_o), .miso_oe_o(miso_oe_o),
		.dma_tx_req_o(dma_tx_req_o), .dma_rx_req_o(dma_rx_req_o));

	dcsp_peer peer (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .ss_i(ss_o[0]), .sck_i(sck_o[0]),
		.mosi_i(mosi_o[0]), .word_i(peer_word), .miso_o(peer_miso), .got_o(peer_got));

	task automatic final_report();
		$display("comparisons %0d mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : final_report

	task automatic cmp_word(input string nm, input logic [31:0] e, input logic [31:0] s);
		cmp_count++;
		if (s !== e) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask : cmp_word

	task automatic cmp_bit(input string nm, input logic e, input logic s);
		cmp_count++;
		if (s !== e) begin
			miscompares++;
			$display("wrong value %s expected %b seen %b", nm, e, s);
		end
	endtask : cmp_bit

	task automatic wr(input logic [AW-1:0] a, input logic [31:0] d);
		@(posedge mclk_i);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge mclk_i);
		wr_i <= 1'b0;
	endtask : wr

	task automatic rd(input logic [AW-1:0] a, input logic [31:0] e, input string nm);
		@(posedge mclk_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		notes.push_back('{e, nm});
		@(posedge mclk_i);
		rd_i <= 1'b0;
	endtask : rd

	task automatic wait_irq();
		for (int i = 0; i < 3000 && irq_o !== 1'b1; i++) @(posedge mclk_i);
		cmp_bit("irq_o raised", 1'b1, irq_o);
	endtask : wait_irq

	// read data stand only in the cycle after the strobe
	always @(posedge mclk_i) begin
		if (rd_seen && notes.size() > 0) begin
			n = notes.pop_front();
			cmp_word(n.name, n.exp, rdata_o);
		end
		rd_seen <= rd_i;
		miso_b  <= ~miso_b;
		// channel 1 lines follow the slave stimulus while it runs, noise otherwise
		sck_i   <= slv_on ? {slv_sck, 1'($urandom)} : 2'($urandom);
		mosi_i  <= slv_on ? {slv_mosi, 1'($urandom)} : 2'($urandom);
		cycles++;
		if (cycles == 30000) begin
			miscompares++;
			final_report();
		end
	end

	initial begin
		logic [31:0] rst_tab [8];
		rst_tab = '{32'h0, 32'h1020, 32'h6, 32'hFF, 32'h0, 32'h10101, 32'h0, 32'h0};
		void'($urandom(32'h2d33ef2e));
		repeat (12) @(posedge mclk_i);
		sys_rst_i <= 1'b0;
		for (int c = 0; c < 2; c++) begin
			for (int k = 0; k < 8; k++) begin
				rd(AW'(c * 256 + k * 4), rst_tab[k], "reset value");
			end
		end
		$display("test reset values done");
		tx = $urandom & 32'h7_FFFF;
		wr(9'h104, tx | 32'h10_0000);
		rd(9'h104, tx, "control readback");
		$display("test control readback done");
		wr(9'h000, 32'h5A);
		rd(9'h008, 32'h04, "status holding full");
		wr(9'h004, 32'h10_0030);
		rd(9'h008, 32'h06, "status after flush");
		$display("test transmit flush done");
		peer_word <= 8'($urandom);
		tx = $urandom & 32'hFF;
		wr(9'h00C, 32'h1);
		wr(9'h018, 32'h20);
		wr(9'h010, 32'h1);
		wr(9'h000, tx);
		wait_irq();
		cmp_bit("sck_oe_o", 1'b1, sck_oe_o[0]);
		cmp_bit("mosi_oe_o", 1'b1, mosi_oe_o[0]);
		cmp_bit("miso_oe_o", 1'b0, miso_oe_o[0]);
		cmp_bit("dma_rx_req_o", 1'b1, dma_rx_req_o[0]);
		cmp_bit("dma_tx_req_o", 1'b1, dma_tx_req_o[0]);
		cmp_word("peer received", tx, {24'h0, peer_got});
		rd(9'h000, {24'h0, peer_word}, "master receive");
		rd(9'h008, 32'h26, "status after frame");
		wr(9'h008, 32'h20);
		repeat (3) @(posedge mclk_i);
		cmp_bit("irq_o cleared", 1'b0, irq_o);
		// select is released only once the stop delay has run out
		cmp_bit("ss_o idle", 1'b1, ss_o[0]);
		cmp_bit("dma_rx_req_o read", 1'b0, dma_rx_req_o[0]);
		$display("test master frame done");
		wr(9'h10C, 32'h1);
		wr(9'h118, 32'h20);
		// random control left by the readback test must not run a frame once enabled
		wr(9'h104, 32'h83C);
		wr(9'h110, 32'h1);
		for (sz = 0; sz < 4; sz++) begin
			base = (sz == 0) ? 8 : (sz == 1) ? 9 : (sz == 2) ? 16 : 17;
			tx = $urandom & ((32'h1 << base) - 1);
			wr(9'h104, 32'h83C | sz);
			wr(9'h100, tx);
			wait_irq();
			cmp_bit("sck_o idle high", 1'b1, sck_o[1]);
			rd(9'h100, tx, "loop-back receive");
			wr(9'h108, 32'h20);
			repeat (3) @(posedge mclk_i);
		end
		$display("test loop-back sizes done");
		slv_word = 8'($urandom);
		tx = $urandom & 32'hFF;
		wr(9'h104, 32'h10);
		wr(9'h100, tx);
		slv_on <= 1'b1;
		repeat (3) @(posedge mclk_i);
		ss_i <= 2'b01;
		for (int i = 7; i >= 0; i--) begin
			slv_mosi <= slv_word[i];
			repeat (3) @(posedge mclk_i);
			slv_got = {slv_got[6:0], miso_o[1]};
			slv_sck <= 1'b1;
			repeat (3) @(posedge mclk_i);
			slv_sck <= 1'b0;
			repeat (3) @(posedge mclk_i);
		end
		cmp_bit("miso_oe_o slave", 1'b1, miso_oe_o[1]);
		cmp_bit("sck_oe_o slave", 1'b0, sck_oe_o[1]);
		cmp_bit("mosi_oe_o slave", 1'b0, mosi_oe_o[1]);
		cmp_bit("ss_oe_o slave", 1'b0, ss_oe_o[1]);
		cmp_word("slave transmit", tx, {24'h0, slv_got});
		rd(9'h100, {24'h0, slv_word}, "slave receive");
		ss_i <= 2'b11;
		slv_on <= 1'b0;
		$display("test slave frame done");
		repeat (4) @(posedge mclk_i);
		final_report();
	end
endmodule : test_dcsp_top
`default_nettype wire
